// [core/legacy_dma_misc_config_regs.sv]
// channel b dma base and misc config registers of configuration space 0
// assumes a host bridge presenting one-cycle dword config read/write strobes
`timescale 1ns/1ps
`include "cfg_regs_cfg.svh"

module legacy_dma_misc_config_regs (
  input  wire logic                MCLK,
  input  wire logic                RST_B,
  input  wire logic                CFG_WR,
  input  wire logic                CFG_RD,
  input  wire logic [7:0]          CFG_ADDR,
  input  wire logic [3:0]          CFG_BE,
  input  wire logic [31:0]         CFG_WDATA,
  output      logic [31:0]         CFG_RDATA,
  output      logic                CFG_RVALID,
  output      cfg_regs_pkg::dma_base_t DMA_B_BASE_ADDR,
  output      cfg_regs_pkg::chan_t DMA_B_CHANNEL,
  output      logic                DMA_B_CHANNEL_ENABLE,
  output      cfg_regs_pkg::duty_t DSP_CLOCK_DUTY_SELECT,
  input  wire logic                MUSIC_REG_FIRST_FULL,
  input  wire logic                MUSIC_REG_SECOND_FULL,
  output      logic                TARGET_RETRY,
  output      logic                SERIAL_CFG_CLOCK_SELECT,
  output      logic                SERIAL_CFG_CLK_SLOW,
  input  wire logic                SERIAL_CFG_DATA_IN,
  output      logic                SERIAL_CFG_DATA_SYNC,
  output      logic                BUS_HOG_FIX_ENABLE,
  output      logic                SIDEBAND_DMA_MODE_ENABLE,
  output      cfg_regs_pkg::chan_t SIDEBAND_CHANNEL_CODE
);
  import cfg_regs_pkg::*;

  // ****************************************************************
  // register storage
  // ****************************************************************
  dma_base_t        base_q;
  chan_t            chan_q;
  logic             en_q;
  misc_config_reg_t misc_q;
  logic [31:0]      rdata_q;
  logic             rvalid_q;
  logic             retry_q;
  logic             sb_en_q;
  chan_t            sb_ch_q;
  logic             sclk_q;
  logic             sdata_q;

  scfg_clk_if sif ();

  scfg_clk_gen u_scfg_clk (
    .MCLK  (MCLK),
    .RST_B (RST_B),
    .sif   (sif)
  );

  assign sif.data_in = SERIAL_CFG_DATA_IN;

  // only the dword part of the byte address selects a register
  function automatic logic dword_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  wire        hit_b    = dword_hit(CFG_ADDR, `DMA_B_DWORD_OFS);
  wire        hit_misc = dword_hit(CFG_ADDR, `MISC_CFG_OFS);
  // lanes 0 and 1 of this dword belong to channel a, which lives outside this bank
  wire        wr_b_lo  = CFG_WR && hit_b && CFG_BE[2];
  wire        wr_b_hi  = CFG_WR && hit_b && CFG_BE[3];
  wire        wr_misc  = CFG_WR && hit_misc && CFG_BE[0];
  // channel b base occupies the upper half of its dword; reserved bits tied low
  wire [15:0] b_view   = {base_q, 1'b0, chan_q, 3'b000, en_q};
  wire [31:0] rdata_d  = hit_b    ? {b_view, 16'h0000} :
                         hit_misc ? {24'h000000, misc_q} :
                                    32'h00000000;
  wire        music_full = MUSIC_REG_FIRST_FULL || MUSIC_REG_SECOND_FULL;

  // ****************************************************************
  // writes
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      base_q <= 9'h000;
      chan_q <= 2'h0;
      en_q   <= 1'b0;
      misc_q <= `MISC_RESET;
    end else begin
      if (wr_b_lo) begin
        base_q[0] <= CFG_WDATA[16 + `DMA_B_BASE_LSB];
        chan_q    <= CFG_WDATA[16 + `DMA_B_CHAN_MSB : 16 + `DMA_B_CHAN_LSB];
        en_q      <= CFG_WDATA[16 + `DMA_B_EN_POS];
      end
      if (wr_b_hi) begin
        base_q[8:1] <= CFG_WDATA[31:24];
      end
      if (wr_misc) begin
        misc_q <= CFG_WDATA[7:0];
      end
    end
  end

  // ****************************************************************
  // reads and registered outputs
  // ****************************************************************
  // a read in the same cycle as a write returns the value from before the write
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= CFG_RD;
      rdata_q  <= CFG_RD ? rdata_d : rdata_q;
    end
  end

  // retry follows the full flags one cycle late while music_retry_enable is set; the host retries anyway
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      retry_q <= 1'b0;
      sb_en_q <= 1'b0;
      sb_ch_q <= 2'h0;
      sclk_q  <= 1'b0;
      sdata_q <= 1'b0;
    end else begin
      retry_q <= misc_q.music_retry_enable && music_full;
      sb_en_q <= misc_q.sideband_dma_mode_enable;
      // mask the code so a stale one never shows while the mode is off
      sb_ch_q <= misc_q.sideband_dma_mode_enable ? misc_q.sideband_channel_code : 2'h0;
      sclk_q  <= sif.clk_slow;
      sdata_q <= sif.data_sync;
    end
  end

  assign CFG_RDATA                = rdata_q;
  assign CFG_RVALID               = rvalid_q;
  assign DMA_B_BASE_ADDR          = base_q;
  assign DMA_B_CHANNEL            = chan_q;
  assign DMA_B_CHANNEL_ENABLE     = en_q;
  assign DSP_CLOCK_DUTY_SELECT    = misc_q.dsp_clock_duty_select;
  assign TARGET_RETRY             = retry_q;
  // the pci clock mux itself sits at the pad, steered by this select
  assign SERIAL_CFG_CLOCK_SELECT  = misc_q.serial_cfg_clock_select;
  assign SERIAL_CFG_CLK_SLOW      = sclk_q;
  assign SERIAL_CFG_DATA_SYNC     = sdata_q;
  assign BUS_HOG_FIX_ENABLE       = misc_q.bus_hog_fix_enable;
  assign SIDEBAND_DMA_MODE_ENABLE = sb_en_q;
  assign SIDEBAND_CHANNEL_CODE    = sb_ch_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_base_hi_write : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_b_hi |=> (base_q[8:1] == $past(CFG_WDATA[31:24]))) else $error("base high lost");
  a_rsvd_six_zero : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RVALID && $past(hit_b) |-> !CFG_RDATA[22]) else $error("bit 6 not zero");
  a_chan_sel_write : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_b_lo |=> (DMA_B_CHANNEL == $past(CFG_WDATA[21:20]))) else $error("channel lost");
  a_rsvd_low_zero : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RVALID && $past(hit_b) |-> (CFG_RDATA[19:17] == 3'b000)) else $error("bits 3:1 set");
  a_enable_follows : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_b_lo |=> (DMA_B_CHANNEL_ENABLE == $past(CFG_WDATA[16]))) else $error("enable wrong");
  a_duty_write : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_misc |=> (DSP_CLOCK_DUTY_SELECT == $past(CFG_WDATA[7:6]))) else $error("duty lost");
  a_retry_cause : assert property (@(posedge MCLK) disable iff (!RST_B)
    TARGET_RETRY == $past(misc_q.music_retry_enable && music_full)) else $error("retry wrong");
  a_sync_on_rise : assert property (@(posedge MCLK) disable iff (!RST_B)
    $changed(sdata_q) |-> $past(sif.clk_slow) && !$past(sif.clk_slow, 2)) else $error("resync off");
  a_sb_chan_gated : assert property (@(posedge MCLK) disable iff (!RST_B)
    !SIDEBAND_DMA_MODE_ENABLE |-> (SIDEBAND_CHANNEL_CODE == 2'h0)) else $error("code leaks");
  a_sb_enable : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_misc ##1 1'b1 |=> (SIDEBAND_DMA_MODE_ENABLE == $past(CFG_WDATA[0], 2))) else $error("sb en");
  a_misc_hold : assert property (@(posedge MCLK) disable iff (!RST_B)
    !wr_misc |=> $stable(misc_q)) else $error("misc changed without write");

  // ****************************************************************
  // checks of the read path and the field outputs
  // ****************************************************************
  a_rvalid_pulse : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD |=> CFG_RVALID) else $error("read not answered");
  a_rvalid_quiet : assert property (@(posedge MCLK) disable iff (!RST_B)
    !CFG_RD |=> !CFG_RVALID) else $error("answer without read");
  a_read_base : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD && hit_b |=> (CFG_RDATA[31:23] == $past(base_q))) else $error("base read wrong");
  a_read_chan_a : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD && hit_b |=> (CFG_RDATA[15:0] == 16'h0000)) else $error("lower half not zero");
  a_read_chan_b : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD && hit_b |=> (CFG_RDATA[21:20] == $past(chan_q))) else $error("channel read wrong");
  a_read_enable : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD && hit_b |=> (CFG_RDATA[16] == $past(en_q))) else $error("enable read wrong");
  a_read_misc : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD && hit_misc |=> (CFG_RDATA == {24'h000000, $past(misc_q)})) else $error("misc read");
  a_read_unmapped : assert property (@(posedge MCLK) disable iff (!RST_B)
    CFG_RD && !hit_b && !hit_misc |=> (CFG_RDATA == 32'h00000000)) else $error("stray data");
  a_base_lo_write : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_b_lo |=> (base_q[0] == $past(CFG_WDATA[23]))) else $error("base bit 7 lost");
  a_base_hold : assert property (@(posedge MCLK) disable iff (!RST_B)
    !wr_b_lo && !wr_b_hi |=> $stable({base_q, chan_q, en_q})) else $error("base changed");
  a_retry_gated : assert property (@(posedge MCLK) disable iff (!RST_B)
    !misc_q.music_retry_enable |=> !TARGET_RETRY) else $error("retry while disabled");
  a_sb_code_follow : assert property (@(posedge MCLK) disable iff (!RST_B)
    SIDEBAND_DMA_MODE_ENABLE |-> (SIDEBAND_CHANNEL_CODE == $past(misc_q.sideband_channel_code)))
    else $error("sideband code wrong");
  a_sclk_select : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_misc |=> (SERIAL_CFG_CLOCK_SELECT == $past(CFG_WDATA[4]))) else $error("select lost");
  a_hog_write : assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_misc |=> (BUS_HOG_FIX_ENABLE == $past(CFG_WDATA[3]))) else $error("hog fix lost");
  a_slow_clk_out : assert property (@(posedge MCLK) disable iff (!RST_B)
    SERIAL_CFG_CLK_SLOW == $past(sif.clk_slow)) else $error("slow clock output off");
endmodule // legacy_dma_misc_config_regs

// [core/cfg_regs_cfg.svh]
// offsets, field positions, reset values and clock rates of the config bank
// assumes byte addresses of configuration space, dword aligned accesses
`ifndef CFG_REGS_CFG_SVH
`define CFG_REGS_CFG_SVH

// ****************************************************************
// offsets
// ****************************************************************
`define DMA_B_BASE_OFS     8'h42
`define DMA_B_DWORD_OFS    8'h40
`define MISC_CFG_OFS       8'h58

// ****************************************************************
// channel b base fields (positions within the 16-bit register)
// ****************************************************************
`define DMA_B_BASE_MSB     15
`define DMA_B_BASE_LSB     7
`define DMA_B_RSVD6_POS    6
`define DMA_B_CHAN_MSB     5
`define DMA_B_CHAN_LSB     4
`define DMA_B_EN_POS       0
`define DMA_B_RESET        16'h0000

// ****************************************************************
// misc config fields
// ****************************************************************
`define MISC_DUTY_MSB      7
`define MISC_DUTY_LSB      6
`define MISC_RETRY_POS     5
`define MISC_SCLK_POS      4
`define MISC_HOG_POS       3
`define MISC_SBCH_MSB      2
`define MISC_SBCH_LSB      1
`define MISC_SBEN_POS      0
`define MISC_RESET         8'h00

// ****************************************************************
// timing
// ****************************************************************
`define MCLK_FREQ_KHZ      100000
`define SCFG_CLK_FREQ_KHZ  400

`endif

// [core/cfg_regs_pkg.sv]
// types shared by the config register bank and its bench
// assumes nothing of its surroundings
package cfg_regs_pkg;
  typedef logic [1:0] chan_t;
  typedef logic [1:0] duty_t;
  typedef logic [8:0] dma_base_t;
  typedef struct packed {
    duty_t dsp_clock_duty_select;
    logic  music_retry_enable;
    logic  serial_cfg_clock_select;
    logic  bus_hog_fix_enable;
    chan_t sideband_channel_code;
    logic  sideband_dma_mode_enable;
  } misc_config_reg_t;
endpackage

// [core/scfg_clk_if.sv]
// link between the register bank and the serial config clock generator
// assumes one clock domain, MCLK
`timescale 1ns/1ps
interface scfg_clk_if;
  logic clk_slow;
  logic data_in;
  logic data_sync;
  modport gen  (output clk_slow, output data_sync, input data_in);
  modport user (input clk_slow, input data_sync, output data_in);
endinterface

// [core/scfg_clk_gen.sv]
// slow serial config port clock and data resynchronised to its rising edge
// assumes MCLK at the rate in cfg_regs_cfg.svh
`timescale 1ns/1ps
`include "cfg_regs_cfg.svh"
module scfg_clk_gen #(
  parameter int HALF_CYCLES = `MCLK_FREQ_KHZ / (2 * `SCFG_CLK_FREQ_KHZ)
) (
  input wire logic MCLK,
  input wire logic RST_B,
  scfg_clk_if.gen  sif
);
  // ****************************************************************
  // divider
  // ****************************************************************
  // the divider counter is 16 bits wide, so longer half periods cannot be served
  if (HALF_CYCLES < 1 || HALF_CYCLES > 65536) begin : g_chk
    $error("HALF_CYCLES must lie between 1 and 65536");
  end

  logic [15:0] cnt_q;
  logic        clk_q;
  logic        data_q;
  wire         wrap = (cnt_q == 16'(HALF_CYCLES - 1));

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_q <= 16'h0000;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      clk_q <= wrap ? ~clk_q : clk_q;
    end
  end

  // incoming data is taken only as the slow clock rises
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      data_q <= 1'b0;
    end else if (wrap && !clk_q) begin
      data_q <= sif.data_in;
    end
  end

  assign sif.clk_slow  = clk_q;
  assign sif.data_sync = data_q;

  a_slow_clk_half : assert property (@(posedge MCLK) disable iff (!RST_B)
    wrap |=> (clk_q != $past(clk_q))) else $error("slow clock did not toggle");
endmodule // scfg_clk_gen

// [dv/cfg_host_model.sv]
// host bridge model issuing one-cycle config read and write strobes
// assumes MCLK from the bench; every change lands 1 ns after a rising edge
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        MCLK,
  output      logic        CFG_WR,
  output      logic        CFG_RD,
  output      logic [7:0]  CFG_ADDR,
  output      logic [3:0]  CFG_BE,
  output      logic [31:0] CFG_WDATA,
  input  wire logic [31:0] CFG_RDATA,
  input  wire logic        CFG_RVALID
);
  initial begin
    CFG_WR = 1'b0;
    CFG_RD = 1'b0;
    CFG_ADDR = 8'h00;
    CFG_BE = 4'h0;
    CFG_WDATA = 32'h0;
  end
  // a released bus shows inverted old values, so stale data never looks fresh
  task automatic idle();
    CFG_WR = 1'b0;
    CFG_RD = 1'b0;
    CFG_ADDR = ~CFG_ADDR;
    CFG_BE = ~CFG_BE;
    CFG_WDATA = ~CFG_WDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge MCLK) #1;
    CFG_WR = 1'b1;
    CFG_ADDR = a;
    CFG_BE = be;
    CFG_WDATA = d;
    @(posedge MCLK) #1;
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(posedge MCLK) #1;
    CFG_RD = 1'b1;
    CFG_ADDR = a;
    CFG_BE = 4'hf;
    @(posedge MCLK) #1;
    idle();
    ok = CFG_RVALID;
    d = CFG_RDATA;
  endtask
endmodule // cfg_host_model

// [dv/legacy_dma_misc_config_regs_tb_top.sv]
// self-checking bench of the channel b base and misc config bank
// assumes the host model file compiled first; MCLK 100 MHz
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module legacy_dma_misc_config_regs_tb_top;
  import cfg_regs_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, full1 = 1'b0, full2 = 1'b0, sdin = 1'b0;
  logic wr, rd, rvalid, en, retry, ssel, sclk, ssync, hog, sben, ok, d0;
  logic [7:0]  addr, m;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, d, e;
  logic [15:0] b;
  dma_base_t   base;
  chan_t       chan, sbch;
  duty_t       duty;
  int          error_cnt = 0, n_tests = 0, cyc = 0, n;
  wire  [54:0] outs = {rdata, base, chan, en, duty, retry, ssel, sclk, ssync, hog, sben, sbch,
                       rvalid};

  cfg_host_model i_host (.MCLK(mclk), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr), .CFG_BE(be),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid));
  legacy_dma_misc_config_regs i_dut (.MCLK(mclk), .RST_B(rst_b), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .DMA_B_BASE_ADDR(base), .DMA_B_CHANNEL(chan), .DMA_B_CHANNEL_ENABLE(en),
    .DSP_CLOCK_DUTY_SELECT(duty), .MUSIC_REG_FIRST_FULL(full1), .MUSIC_REG_SECOND_FULL(full2),
    .TARGET_RETRY(retry), .SERIAL_CFG_CLOCK_SELECT(ssel), .SERIAL_CFG_CLK_SLOW(sclk),
    .SERIAL_CFG_DATA_IN(sdin), .SERIAL_CFG_DATA_SYNC(ssync), .BUS_HOG_FIX_ENABLE(hog),
    .SIDEBAND_DMA_MODE_ENABLE(sben), .SIDEBAND_CHANNEL_CODE(sbch));

  initial begin
    forever #5 mclk = ~mclk;
  end
  // ceiling well above the thousand or so cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // only base 15:7, channel 5:4 and enable 0 are kept; the rest reads zero
  function automatic logic [15:0] upd_b(input logic [15:0] o, input logic [3:0] l,
                                        input logic [31:0] v);
    if (l[2]) o[7:0] = v[23:16];
    if (l[3]) o[15:8] = v[31:24];
    return o & 16'hffb1;
  endfunction
  task automatic wr_b(input logic [3:0] l, input logic [31:0] v);
    b = upd_b(b, l, v);
    i_host.wr(8'h40, l, v);
    `CHK("base", b[15:7], base)
    `CHK("chan", b[5:4], chan)
    `CHK("en", b[0], en)
    i_host.rd(8'h40, d, ok);
    `CHK("rvalid", 1'b1, ok)
    `CHK("b_read", {b, 16'h0000}, d)
    @(posedge mclk) #1;
    `CHK("rvalid_end", 1'b0, rvalid)
  endtask
  task automatic wr_m(input logic [3:0] l, input logic [7:0] v);
    if (l[0]) m = v;
    i_host.wr(8'h58, l, {24'h0, v});
    `CHK("duty", m[7:6], duty)
    `CHK("ssel", m[4], ssel)
    `CHK("hog", m[3], hog)
    @(posedge mclk) #1;
    `CHK("sben", m[0], sben)
    `CHK("sbch", m[0] ? m[2:1] : 2'b00, sbch)
    i_host.rd(8'h58, d, ok);
    `CHK("m_read", {24'h0, m}, d)
  endtask
  task automatic run_lvl(input logic lvl, output int c);
    c = 0;
    while (sclk === lvl && c < 400) begin
      @(posedge mclk) #1;
      c++;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    void'($urandom(21677));
    b = 16'h0000;
    m = 8'h00;
    repeat (20) @(posedge mclk);
    #1;
    `CHK("rst_out", 55'h0, outs)
    rst_b = 1'b1;
    i_host.rd(8'h40, d, ok);
    `CHK("rst_b", 32'h0, d)
    $display("reset test done");
    // channel a taken as 0x0291: same base and enable, channel 2 against its channel 1
    wr_b(4'hc, 32'h02a1_0000);
    wr_b(4'hc, 32'hffff_ffff);
    wr_b(4'h8, 32'h0000_0000);
    repeat (24) wr_b(4'($urandom), $urandom);
    $display("base test done");
    wr_m(4'h1, 8'hff);
    wr_m(4'h1, 8'hfe);
    wr_m(4'he, 8'h00);
    repeat (24) wr_m(4'($urandom), 8'($urandom));
    $display("misc test done");
    i_host.wr(8'h5c, 4'hf, $urandom);
    i_host.rd(8'h5c, d, ok);
    `CHK("unmapped", 32'h0, d)
    i_host.rd(8'h40, d, ok);
    `CHK("b_kept", {b, 16'h0000}, d)
    i_host.rd(8'h58, d, ok);
    `CHK("m_kept", {24'h0, m}, d)
    $display("unmapped test done");
    // reset again in mid-run with both registers loaded
    wr_b(4'hc, 32'hffff_0000);
    wr_m(4'h1, 8'hff);
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("rst_mid", 55'h0, outs)
    rst_b = 1'b1;
    b = 16'h0000;
    m = 8'h00;
    i_host.rd(8'h40, d, ok);
    `CHK("rst_mid_b", 32'h0, d)
    i_host.rd(8'h58, d, ok);
    `CHK("rst_mid_m", 32'h0, d)
    $display("mid-run reset test done");
    for (int r = 0; r < 2; r++) begin
      wr_m(4'h1, 8'(r) << 5);
      repeat (10) begin
        {full1, full2} = 2'($urandom);
        repeat (2) @(posedge mclk);
        #1;
        `CHK("retry", 1'(r) & (full1 | full2), retry)
      end
    end
    $display("retry test done");
    wr_m(4'h1, 8'h00);
    run_lvl(1'b1, n);
    d0 = 1'($urandom);
    sdin = d0;
    run_lvl(1'b0, n);
    sdin = ~d0;
    run_lvl(1'b1, n);
    `CHK("s_high", 125, n)
    `CHK("s_sync", d0, ssync)
    run_lvl(1'b0, n);
    `CHK("s_low", 125, n)
    `CHK("s_sync_next", ~d0, ssync)
    $display("serial clock test done");
    finish_test();
  end
endmodule // legacy_dma_misc_config_regs_tb_top
